// [core/compat_link.v]
// Overview of operation
// - with tx addressing on, destination address goes out; resets to 0x00ff.
// - with rx addressing on, local address is own station; resets to zero.
// - accept received message if local address matches or broadcast 255.
// - in option 3 both rx and tx address filtering are forced off.
// - compatibility modes force native error check and crc check off.
// - native fec suspended in option 3, restored when mode is left.
// - repeater stays usable; command R enables it, O disables it.
// - in 4fsk, gmsk, option 3 buffer whole serial message till a gap.
// - message-ending gap counted in serial byte intervals.
// - radio message fully received before any serial output starts.
// - symbol rate per mode and channel width as tabled.
// - raw data rate reported as two thirds of symbol rate.
// - addressed peer networks need transmit delay of at least 50 ms; txdly_r resets to 0 and no minimum is enforced.
// - broadcast use needs none; 34 ms gives peer-like latency.
// - no automatic retransmission or acknowledgement is performed.
// - priority bit selects rx or tx priority; tx is the default.
// - with test mode on, a single test message goes out once per reset.
// - received test messages are handled as ordinary data.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "compat_link_consts.vh"
module compat_link (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// serial side, host to radio
	input wire [7:0] ser_rx_data,
	input wire ser_rx_valid,
	// radio transmit side
	output reg [7:0] rf_tx_data,
	output reg rf_tx_valid,
	output reg rf_tx_last,
	output reg [7:0] rf_tx_dest,
	output reg rf_tx_test,
	// radio receive side
	input wire [7:0] rf_rx_data,
	input wire rf_rx_valid,
	input wire rf_rx_last,
	input wire [7:0] rf_rx_src_dest,
	// serial side, radio to host
	output reg [7:0] ser_tx_data,
	output reg ser_tx_valid,
	// modem status
	output reg fec_active,
	output reg repeater_on,
	output reg rx_priority
);
	localparam DEPTH = 1024;
	localparam AW = 10;
	localparam S_IDLE = 2'd0;
	localparam S_FILL = 2'd1;
	localparam S_WAIT = 2'd2;
	localparam S_SEND = 2'd3;
	localparam T_IDLE = 2'd0;
	localparam T_FILL = 2'd1;
	localparam T_OUT = 2'd2;

	reg [31:0] ctrl_r;
	reg [15:0] dest_r;
	reg [15:0] local_r;
	reg [15:0] pause_r;
	reg [15:0] byte_cyc_r;
	reg [15:0] txdly_r;
	reg fec_saved_r;
	reg [7:0] tbuf [0:DEPTH-1];
	reg [7:0] rbuf [0:DEPTH-1];
	reg [1:0] ts_r;
	reg [AW:0] tcnt_r;
	reg [AW:0] tidx_r;
	reg [15:0] gap_cyc_r;
	reg [15:0] gap_bytes_r;
	// 34 bits so the longest delay in cycles cannot wrap
	reg [33:0] dly_r;
	reg test_pend_r;
	reg [1:0] rs_r;
	reg [AW:0] rcnt_r;
	reg [AW:0] ridx_r;
	reg rx_ok_r;
	reg [7:0] drop_cnt_r;
	wire [3:0] mode;
	wire compat;
	wire store_fwd;
	wire tx_addr_en;
	wire rx_addr_en;
	wire wr;
	wire rd;
	reg [31:0] sym_rate;
	reg [31:0] rd_mux;

	assign mode = ctrl_r[`C_MODE_HI:`C_MODE_LO];
	assign compat = (mode != `MODE_NATIVE);
	// addressing is meaningless in option 3, so mask both enables
	assign tx_addr_en = ctrl_r[`C_TXADDR] & (mode != `MODE_OPT3);
	assign rx_addr_en = ctrl_r[`C_RXADDR] & (mode != `MODE_OPT3);
	assign store_fwd = (mode == `MODE_4FSK) | (mode == `MODE_GMSK) |
		(mode == `MODE_OPT3);
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;

	// symbol rate lookup by mode and channel width
	always @* begin
		case (mode)
		`MODE_4FSK, `MODE_FST:
			sym_rate = ctrl_r[`C_W25] ? `RATE_19200 : `RATE_9600;
		`MODE_GMSK, `MODE_OPT3:
			sym_rate = ctrl_r[`C_W25] ? `RATE_9600 : `RATE_4800;
		default:
			sym_rate = 32'h0000_0000;
		endcase
	end

	// read mux; unmapped offsets read zero, with an error only above the rate offset
	always @* begin
		case (paddr)
		`OFF_CTRL: rd_mux = ctrl_r;
		`OFF_DEST: rd_mux = {16'h0000, dest_r};
		`OFF_LOCAL: rd_mux = {16'h0000, local_r};
		`OFF_PAUSE: rd_mux = {byte_cyc_r, pause_r};
		`OFF_TXDLY: rd_mux = {16'h0000, txdly_r};
		`OFF_STATUS: rd_mux = {drop_cnt_r, 16'h0000, 1'b0, rx_ok_r,
			ts_r, rs_r, tx_addr_en, rx_addr_en};
		// raw rate is two thirds of the symbol rate
		`OFF_RATE: rd_mux = (sym_rate << 1) / 32'd3;
		default: rd_mux = 32'h0000_0000;
		endcase
	end

	// apb slave, zero wait states; pready is high in every access phase
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > `OFF_RATE);
			if (psel & ~penable & ~pwrite)
				prdata <= rd_mux;
		end
	end

	// register writes take effect on the access edge
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= `CTRL_RST;
			dest_r <= `DEST_RST;
			local_r <= `LOCAL_RST;
			pause_r <= `PAUSE_RST;
			byte_cyc_r <= `BYTE_CYC_RST;
			txdly_r <= `TXDLY_RST;
			fec_saved_r <= 1'b0;
		end else begin
			if (wr && pready) begin
				case (paddr)
				`OFF_CTRL: begin
					ctrl_r <= pwdata;
					// entering option 3 parks fec, leaving restores it
					if (pwdata[`C_MODE_HI:`C_MODE_LO] == `MODE_OPT3 &&
						mode != `MODE_OPT3) begin
						fec_saved_r <= pwdata[`C_FEC];
						ctrl_r[`C_FEC] <= 1'b0;
					end else if (mode == `MODE_OPT3 &&
						pwdata[`C_MODE_HI:`C_MODE_LO] != `MODE_OPT3)
						ctrl_r[`C_FEC] <= fec_saved_r;
					else if (pwdata[`C_MODE_HI:`C_MODE_LO] == `MODE_OPT3)
						ctrl_r[`C_FEC] <= 1'b0;
					// outside native mode, error check and crc check are forced off
					if (pwdata[`C_MODE_HI:`C_MODE_LO] != `MODE_NATIVE) begin
						ctrl_r[`C_ECHK] <= 1'b0;
						ctrl_r[`C_CRC] <= 1'b0;
					end
				end
				`OFF_DEST: dest_r <= pwdata[15:0];
				`OFF_LOCAL: local_r <= pwdata[15:0];
				`OFF_PAUSE: begin
					pause_r <= pwdata[15:0];
					byte_cyc_r <= pwdata[31:16];
				end
				`OFF_TXDLY: txdly_r <= pwdata[15:0];
				// repeater command byte: R on, O off, others ignored
				`OFF_STATUS: begin
					if (pwdata[7:0] == `REP_CMD_ON)
						ctrl_r[`C_REP] <= 1'b1;
					else if (pwdata[7:0] == `REP_CMD_OFF)
						ctrl_r[`C_REP] <= 1'b0;
				end
				default: ;
				endcase
			end
		end
	end

	// status outputs from flops
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fec_active <= 1'b0;
			repeater_on <= 1'b0;
			rx_priority <= 1'b0;
		end else begin
			fec_active <= ctrl_r[`C_FEC] & ~compat;
			repeater_on <= ctrl_r[`C_REP];
			rx_priority <= ctrl_r[`C_PRIO];
		end
	end

	// transmit path: in store-forward modes gather until a pause, wait tx delay, then send.
	// one message goes out once; no retry and no ack wait
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ts_r <= T_IDLE;
			tcnt_r <= {(AW+1){1'b0}};
			tidx_r <= {(AW+1){1'b0}};
			gap_cyc_r <= 16'h0000;
			gap_bytes_r <= 16'h0000;
			dly_r <= 34'h0;
			test_pend_r <= 1'b1;
			rf_tx_data <= 8'h00;
			rf_tx_valid <= 1'b0;
			rf_tx_last <= 1'b0;
			rf_tx_dest <= `BCAST;
			rf_tx_test <= 1'b0;
		end else begin
			rf_tx_valid <= 1'b0;
			rf_tx_last <= 1'b0;
			case (ts_r)
			T_IDLE: begin
				tidx_r <= {(AW+1){1'b0}};
				if (ser_rx_valid) begin
					tbuf[0] <= ser_rx_data;
					tcnt_r <= {{AW{1'b0}}, 1'b1};
					gap_cyc_r <= 16'h0000;
					gap_bytes_r <= 16'h0000;
					ts_r <= store_fwd ? T_FILL : T_OUT;
					dly_r <= 34'h0;
				end else if (test_pend_r && ctrl_r[`C_TEST]) begin
					// one test frame per reset; the flag is cleared here and
					// only reset arms it again, which also clears the test bit
					tcnt_r <= {(AW+1){1'b0}};
					dly_r <= 34'h0;
					test_pend_r <= 1'b0;
					ts_r <= T_OUT;
				end
			end
			T_FILL: begin
				if (ser_rx_valid && tcnt_r < DEPTH) begin
					tbuf[tcnt_r[AW-1:0]] <= ser_rx_data;
					tcnt_r <= tcnt_r + 1'b1;
					gap_cyc_r <= 16'h0000;
					gap_bytes_r <= 16'h0000;
				end else if (gap_cyc_r >= byte_cyc_r) begin
					// one idle byte interval elapsed
					gap_cyc_r <= 16'h0000;
					gap_bytes_r <= gap_bytes_r + 1'b1;
					if (gap_bytes_r + 16'h0001 >= pause_r)
						ts_r <= T_OUT;
				end else
					gap_cyc_r <= gap_cyc_r + 1'b1;
			end
			T_OUT: begin
				if (dly_r < txdly_r * `MS_CYC)
					dly_r <= dly_r + 1'b1;
				else begin
					rf_tx_valid <= 1'b1;
					rf_tx_data <= (tcnt_r == 0) ? `TEST_BYTE :
						tbuf[tidx_r[AW-1:0]];
					rf_tx_test <= (tcnt_r == 0);
					// address goes out only with tx addressing on
					rf_tx_dest <= tx_addr_en ? dest_r[7:0] : `BCAST;
					tidx_r <= tidx_r + 1'b1;
					if (tcnt_r == 0 || tidx_r + 1'b1 >= tcnt_r) begin
						rf_tx_last <= 1'b1;
						ts_r <= T_IDLE;
					end
				end
			end
			default: ts_r <= T_IDLE;
			endcase
		end
	end

	// receive path: filter on low address byte, store the frame whole,
	// then replay to serial; test frames are not singled out
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rs_r <= S_IDLE;
			rcnt_r <= {(AW+1){1'b0}};
			ridx_r <= {(AW+1){1'b0}};
			rx_ok_r <= 1'b0;
			drop_cnt_r <= 8'h00;
			ser_tx_data <= 8'h00;
			ser_tx_valid <= 1'b0;
		end else begin
			ser_tx_valid <= 1'b0;
			case (rs_r)
			S_IDLE: begin
				rcnt_r <= {(AW+1){1'b0}};
				ridx_r <= {(AW+1){1'b0}};
				if (rf_rx_valid) begin
					rx_ok_r <= ~rx_addr_en ||
						rf_rx_src_dest == local_r[7:0] ||
						rf_rx_src_dest == `BCAST;
					rbuf[0] <= rf_rx_data;
					rcnt_r <= {{AW{1'b0}}, 1'b1};
					rs_r <= rf_rx_last ? S_WAIT : S_FILL;
				end
			end
			S_FILL: if (rf_rx_valid) begin
				if (rcnt_r < DEPTH) begin
					rbuf[rcnt_r[AW-1:0]] <= rf_rx_data;
					rcnt_r <= rcnt_r + 1'b1;
				end
				if (rf_rx_last)
					rs_r <= S_WAIT;
			end
			// output begins only after the last byte
			S_WAIT: begin
				if (!rx_ok_r) begin
					drop_cnt_r <= drop_cnt_r + 1'b1;
					rs_r <= S_IDLE;
				end else
					rs_r <= S_SEND;
			end
			S_SEND: begin
				ser_tx_valid <= 1'b1;
				ser_tx_data <= rbuf[ridx_r[AW-1:0]];
				ridx_r <= ridx_r + 1'b1;
				if (ridx_r + 1'b1 >= rcnt_r)
					rs_r <= S_IDLE;
			end
			default: rs_r <= S_IDLE;
			endcase
		end
	end
endmodule // compat_link

// [core/compat_link_consts.vh]
`ifndef COMPAT_LINK_CONSTS_VH
`define COMPAT_LINK_CONSTS_VH
// apb register byte offsets
`define OFF_CTRL 12'h000
`define OFF_DEST 12'h004
`define OFF_LOCAL 12'h008
`define OFF_PAUSE 12'h00c
`define OFF_TXDLY 12'h010
`define OFF_STATUS 12'h014
`define OFF_RATE 12'h018
// control fields
`define CTRL_RST 32'h0000_0002
`define C_TXADDR 0
`define C_RXADDR 1
`define C_FEC 2
`define C_ECHK 3
`define C_CRC 4
`define C_REP 5
`define C_PRIO 6
`define C_TEST 7
`define C_W25 8
`define C_MODE_LO 12
`define C_MODE_HI 15
// native mode and compatibility modes
`define MODE_NATIVE 4'h0
`define MODE_4FSK 4'h1
`define MODE_GMSK 4'h2
`define MODE_OPT3 4'h3
`define MODE_FST 4'h5
// address resets and broadcast
`define DEST_RST 16'h00ff
`define LOCAL_RST 16'h0000
`define BCAST 8'hff
// repeater command values
`define REP_CMD_ON 8'h52
`define REP_CMD_OFF 8'h4f
// symbol rates, bps
`define RATE_4800 32'd4800
`define RATE_9600 32'd9600
`define RATE_19200 32'd19200
// timing
`define CLK_HZ 250000000
`define MS_CYC (`CLK_HZ / 1000)
`define TXDLY_MIN_MS 16'd50
`define TXDLY_BC_MS 16'd34
`define TXDLY_RST 16'h0000
`define TEST_BYTE 8'h54
`define PAUSE_RST 16'h0003
`define BYTE_CYC_RST 16'h0000
`endif

// [test/compat_link_monitor.sv]
`timescale 1ns/1ns
module compat_link_monitor (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	// radio and serial
	input wire rf_rx_valid,
	input wire rf_rx_last,
	input wire ser_tx_valid,
	input wire [7:0] rf_tx_data,
	input wire rf_tx_valid,
	input wire rf_tx_last,
	input wire [7:0] rf_tx_dest,
	input wire rf_tx_test,
	// status levels
	input wire fec_active,
	input wire repeater_on,
	input wire rx_priority
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire wr = psel && penable && pready && pwrite;
	reg in_frame_r;
	// open radio frame; the host side must stay quiet until its last byte
	always @(posedge core_clk or posedge rst) begin
		if (rst)
			in_frame_r <= 1'b0;
		else if (rf_rx_valid)
			in_frame_r <= !rf_rx_last;
	end
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no answer in access phase");
	chk_slverr_unmapped: assert property (pslverr |-> pready && paddr > 12'h018)
		else $error("error on mapped address");
	chk_dest_reset: assert property ($fell(rst) |-> rf_tx_dest == 8'hff)
		else $error("recipient not broadcast after reset");
	chk_rx_whole: assert property (in_frame_r |-> !ser_tx_valid)
		else $error("host output during radio frame");
	chk_test_byte: assert property (rf_tx_test && rf_tx_valid |->
		rf_tx_data == 8'h54 && rf_tx_last)
		else $error("bad test frame");
	chk_last_valid: assert property (rf_tx_last |-> rf_tx_valid)
		else $error("last flag without byte");
	chk_opt3_fec: assert property (wr && paddr == 12'h000 &&
		pwdata[15:12] == 4'h3 |-> ##2 !fec_active)
		else $error("correction kept in option 3");
	chk_rep_cmd: assert property (wr && paddr == 12'h014 &&
		pwdata[7:0] == 8'h52 |-> ##2 repeater_on)
		else $error("repeater not enabled");
	chk_prio_level: assert property (wr && paddr == 12'h000 |->
		##2 rx_priority == $past(pwdata[6], 2))
		else $error("priority level wrong");
	cover property (rf_tx_last);
	cover property (ser_tx_valid);
	cover property (pslverr);
endmodule // compat_link_monitor
bind compat_link compat_link_monitor u_mon (.core_clk, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .rf_rx_valid, .rf_rx_last,
	.ser_tx_valid, .rf_tx_data, .rf_tx_valid, .rf_tx_last, .rf_tx_dest,
	.rf_tx_test, .fec_active, .repeater_on, .rx_priority);

// [test/peer_modem.sv]
`timescale 1ns/1ns
module peer_modem #(
	parameter [7:0] local_addr = 8'h05,
	parameter [7:0] security_code = 8'h00
) (
	// clock
	input wire core_clk,
	// frames towards the device
	output logic [7:0] rf_rx_data,
	output logic rf_rx_valid,
	output logic rf_rx_last,
	output logic [7:0] rf_rx_src_dest,
	// frames from the device
	input wire [7:0] rf_tx_data,
	input wire rf_tx_valid,
	input wire rf_tx_last,
	input wire [7:0] rf_tx_dest
);
	logic [7:0] heard_q[$];
	logic [7:0] heard_dest;
	int n_last = 0;
	initial begin
		rf_rx_data = 8'h00;
		rf_rx_valid = 1'b0;
		rf_rx_last = 1'b0;
		rf_rx_src_dest = 8'h00;
	end
	// only frames for our station or broadcast; no security code in use
	always @(posedge core_clk) begin
		if (rf_tx_valid && security_code == 8'h00 &&
			(rf_tx_dest == local_addr || rf_tx_dest == 8'hff)) begin
			heard_q.push_back(rf_tx_data);
			heard_dest = rf_tx_dest;
			n_last += rf_tx_last;
		end
	end
	// one frame, a byte per cycle; no acknowledge is ever expected
	task automatic send(input logic [7:0] dest, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			rf_rx_valid <= 1'b1;
			rf_rx_last <= (i == n - 1);
			rf_rx_data <= 8'h30 + i[7:0];
			rf_rx_src_dest <= dest;
		end
		@(posedge core_clk);
		rf_rx_valid <= 1'b0;
		rf_rx_last <= 1'b0;
		// released lines must not keep the last value
		rf_rx_data <= ~rf_rx_data;
		rf_rx_src_dest <= ~rf_rx_src_dest;
	endtask
endmodule // peer_modem

// [test/test_compat_mode_addressed_packet_link.sv]
`timescale 1ns/1ns
`include "compat_link_consts.vh"
module test_compat_mode_addressed_packet_link;
	logic core_clk, rst, psel, penable, pwrite, ser_rx_valid, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd, sym;
	logic [7:0] ser_rx_data;
	wire [31:0] prdata;
	wire [7:0] rf_tx_data, rf_tx_dest, rf_rx_data, rf_rx_src_dest, ser_tx_data;
	wire pready, pslverr, rf_tx_valid, rf_tx_last, rf_tx_test, rf_rx_valid;
	wire rf_rx_last, ser_tx_valid, fec_active, repeater_on, rx_priority;
	logic [7:0] got_q[$];
	logic [3:0] mtab[4] = '{`MODE_4FSK, `MODE_GMSK, `MODE_OPT3, `MODE_FST};
	int n_fail = 0;
	int n_compared = 0;
	int n_test = 0;
	compat_link DUT (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ser_rx_data, .ser_rx_valid, .rf_tx_data,
		.rf_tx_valid, .rf_tx_last, .rf_tx_dest, .rf_tx_test, .rf_rx_data,
		.rf_rx_valid, .rf_rx_last, .rf_rx_src_dest, .ser_tx_data, .ser_tx_valid,
		.fec_active, .repeater_on, .rx_priority);
	peer_modem peer (.core_clk, .rf_rx_data, .rf_rx_valid, .rf_rx_last,
		.rf_rx_src_dest, .rf_tx_data, .rf_tx_valid, .rf_tx_last, .rf_tx_dest);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// host-side bytes and test frames seen leaving the block
	always @(posedge core_clk) begin
		if (ser_tx_valid)
			got_q.push_back(ser_tx_data);
		if (rf_tx_valid && rf_tx_test)
			n_test++;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// bounded wait on a counter
	task automatic wait_for(ref int c, input int t);
		for (int i = 0; i < 1000 && c < t; i++)
			@(posedge core_clk);
		if (c < t) begin
			n_fail++;
			end_of_test();
		end
	endtask
	initial begin
		{psel, penable, pwrite, ser_rx_valid, paddr, pwdata, ser_rx_data} = '0;
		rst = 1'b1;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		chk(rf_tx_dest, 8'hff);
		chk(rx_priority, 1'b0);
		apb(0, `OFF_CTRL, 0);
		chk(rd, `CTRL_RST);
		apb(0, `OFF_DEST, 0);
		chk(rd, {16'h0, `DEST_RST});
		apb(0, `OFF_LOCAL, 0);
		chk(rd, {16'h0, `LOCAL_RST});
		apb(0, `OFF_PAUSE, 0);
		chk(rd, {`BYTE_CYC_RST, `PAUSE_RST});
		apb(0, 12'h01c, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b1);
		// every compatibility mode and width; check and crc bits are asked for too
		for (int m = 0; m < 8; m++) begin
			apb(1, `OFF_CTRL, {16'h0, mtab[m / 2], 3'h0, m[0], 8'h18});
			apb(0, `OFF_CTRL, 0);
			chk(rd[4:3], 2'b00);
			apb(0, `OFF_RATE, 0);
			sym = (mtab[m / 2] == `MODE_GMSK || mtab[m / 2] == `MODE_OPT3) ?
				`RATE_4800 : `RATE_9600;
			chk(rd, (sym << m[0]) * 2 / 3);
		end
		apb(1, `OFF_CTRL, 32'h0000_3007);
		apb(0, `OFF_STATUS, 0);
		chk({rd[1:0], fec_active}, 3'b000);
		// correction bit written low: leaving option 3 must restore it
		apb(1, `OFF_CTRL, 32'h0000_0000);
		apb(0, `OFF_CTRL, 0);
		chk(fec_active, 1'b1);
		apb(1, `OFF_STATUS, {24'h0, `REP_CMD_ON});
		apb(0, `OFF_CTRL, 0);
		chk(repeater_on, 1'b1);
		apb(1, `OFF_STATUS, {24'h0, `REP_CMD_OFF});
		apb(0, `OFF_CTRL, 0);
		chk(repeater_on, 1'b0);
		apb(1, `OFF_CTRL, 32'h0000_0040);
		apb(0, `OFF_CTRL, 0);
		chk(rx_priority, 1'b1);
		// receive filter on low address byte: own, foreign, broadcast
		apb(1, `OFF_LOCAL, 32'h0000_0105);
		apb(1, `OFF_CTRL, 32'h0000_1002);
		peer.send(8'h05, 2);
		repeat (10) @(posedge core_clk);
		peer.send(8'h06, 2);
		repeat (10) @(posedge core_clk);
		peer.send(`BCAST, 3);
		repeat (10) @(posedge core_clk);
		chk(got_q.size(), 5);
		chk({got_q[1], got_q[4]}, 16'h3132);
		// whole host message held until the pause, then sent addressed
		apb(1, `OFF_PAUSE, 32'h0000_0004);
		apb(1, `OFF_TXDLY, 0);
		apb(1, `OFF_DEST, 32'h0000_0005);
		apb(1, `OFF_CTRL, 32'h0000_1001);
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			ser_rx_valid <= 1'b1;
			ser_rx_data <= 8'h61 + i[7:0];
		end
		@(posedge core_clk);
		ser_rx_valid <= 1'b0;
		chk(peer.heard_q.size(), 0);
		wait_for(peer.n_last, 1);
		chk(peer.heard_q.size(), 3);
		chk({peer.heard_dest, peer.heard_q[2]}, 16'h0563);
		apb(1, `OFF_CTRL, 32'h0000_0080);
		wait_for(n_test, 1);
		chk(n_test, 1);
		// reset in mid-run re-arms exactly one more test frame
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		chk(rf_tx_dest, `BCAST);
		apb(1, `OFF_CTRL, 32'h0000_0080);
		wait_for(n_test, 2);
		chk(n_test, 2);
		end_of_test();
	end
endmodule // test_compat_mode_addressed_packet_link
